// ---- hw/acr_advanced_control.sv ----
`include "acr_consts.svh"

module acr_advanced_control #(
  parameter int unsigned STALL_CYCLES = `ACR_STALL_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // decoded bus commands
  input wire logic cmd_valid_in,
  input wire logic cmd_write_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic [15:0] cmd_wdata_in,
  output logic [15:0] cmd_rdata_out,
  output logic cmd_done_out,
  output logic cmd_refused_out,
  // bus address phase
  input wire logic addr_match_in,
  output logic addr_ack_out,
  input wire logic write_in_progress_in,
  // device busy status
  input wire logic init_busy_in,
  input wire logic nvm_busy_in,
  // low-power sequencing
  input wire logic lpm_request_in,
  input wire logic lpm_wake_in,
  output logic low_power_state_out,
  output logic reinit_request_out,
  // turn-on and fault handling
  input wire logic turn_on_in,
  output logic restore_request_out,
  output logic clear_recorded_fault_out,
  output logic crc_enable_out,
  // calculation machine watch
  input wire logic [7:0] calc_state_in,
  output logic calc_reset_out,
  // clock gate enables
  output logic nvm_clk_en_out,
  output logic reg_write_clk_en_out,
  output logic bus_clk_gating_en_out,
  // analog settings passed through
  output logic bus_voltage_sel_out,
  output logic bandgap_chop_en_out
);

  acr_pkg::acr_word_t advanced_control;
  acr_pkg::acr_word_t next_advanced_control;
  logic [15:0] next_rdata;
  logic next_done;
  logic next_refused;
  logic next_clear_fault;
  logic next_restore;
  logic nvm_gate_open;
  logic next_nvm_gate_open;
  logic nvm_busy_d;
  acr_pkg::acr_lpm_state_t lpm_state;
  acr_pkg::acr_lpm_state_t next_lpm_state;
  logic busy;
  logic accept;
  logic is_write_ctrl;
  logic is_read_ctrl;
  logic is_clear;
  logic is_nvm_cmd;

  // device cannot serve commands while initialising or moving NVM
  assign busy = init_busy_in | nvm_busy_in;
  assign accept = cmd_valid_in & ~busy;
  assign is_write_ctrl = accept & cmd_write_in &
    (cmd_code_in == `ACR_CMD_ADV_CTRL);
  assign is_read_ctrl = accept & ~cmd_write_in &
    (cmd_code_in == `ACR_CMD_ADV_CTRL);
  assign is_clear = accept & cmd_write_in &
    (cmd_code_in == `ACR_CMD_CLEAR_FAULTS);
  assign is_nvm_cmd = accept & cmd_write_in &
    ((cmd_code_in == `ACR_CMD_NVM_STORE) |
     (cmd_code_in == `ACR_CMD_NVM_RESTORE));

  // command handling: control word access and side-effect commands
  always_comb begin
    next_advanced_control = advanced_control;
    next_rdata = cmd_rdata_out;
    next_done = 1'b0;
    next_refused = 1'b0;
    next_clear_fault = 1'b0;
    if (is_write_ctrl) begin
      next_advanced_control = cmd_wdata_in; // reserved bits kept as written
      next_done = 1'b1;
    end
    if (is_read_ctrl) begin
      next_rdata = advanced_control;
      next_done = 1'b1;
    end
    if (is_clear) begin
      next_clear_fault = advanced_control[`ACR_BIT_CLR_REC_FAULT];
      next_done = 1'b1;
    end
    if (is_nvm_cmd) begin
      next_done = 1'b1;
    end
    if (cmd_valid_in && busy) begin
      next_refused = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      advanced_control <= `ACR_CTRL_RESET;
      cmd_rdata_out <= 16'h0000;
      cmd_done_out <= 1'b0;
      cmd_refused_out <= 1'b0;
      clear_recorded_fault_out <= 1'b0;
    end else begin
      advanced_control <= next_advanced_control;
      cmd_rdata_out <= next_rdata;
      cmd_done_out <= next_done;
      cmd_refused_out <= next_refused;
      clear_recorded_fault_out <= next_clear_fault;
    end
  end

  assign addr_ack_out = addr_match_in &
    ~(busy & advanced_control[`ACR_BIT_BUS_RESP_INIT]);

  // low-power sequencing; dropping the enable forces an exit
  always_comb begin
    next_lpm_state = lpm_state;
    case (lpm_state)
      acr_pkg::ACR_ACTIVE: begin
        if (lpm_request_in && advanced_control[`ACR_BIT_LPM_ENABLE]) begin
          next_lpm_state = acr_pkg::ACR_LOW_POWER;
        end
      end
      acr_pkg::ACR_LOW_POWER: begin
        if (lpm_wake_in || !advanced_control[`ACR_BIT_LPM_ENABLE]) begin
          next_lpm_state = acr_pkg::ACR_WAKE;
        end
      end
      acr_pkg::ACR_WAKE: begin
        next_lpm_state = acr_pkg::ACR_ACTIVE;
      end
      default: begin
        next_lpm_state = acr_pkg::ACR_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      lpm_state <= acr_pkg::ACR_ACTIVE;
    end else begin
      lpm_state <= next_lpm_state;
    end
  end

  assign low_power_state_out = (lpm_state == acr_pkg::ACR_LOW_POWER);
  assign reinit_request_out = (lpm_state == acr_pkg::ACR_WAKE) &
    advanced_control[`ACR_BIT_REINIT_LPM_EXIT];

  // nvm gate opens on store/restore, closes when the transfer ends
  always_comb begin
    next_restore = 1'b0;
    next_nvm_gate_open = nvm_gate_open;
    if (turn_on_in && advanced_control[`ACR_BIT_RESTORE_ON]) begin
      next_restore = 1'b1;
    end
    if (nvm_busy_d && !nvm_busy_in) begin
      next_nvm_gate_open = 1'b0;
    end
    if (is_nvm_cmd || next_restore) begin
      next_nvm_gate_open = 1'b1; // set wins over the close
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      restore_request_out <= 1'b0;
      nvm_gate_open <= 1'b0;
      nvm_busy_d <= 1'b0;
    end else begin
      restore_request_out <= next_restore;
      nvm_gate_open <= next_nvm_gate_open;
      nvm_busy_d <= nvm_busy_in;
    end
  end

  assign nvm_clk_en_out = ~advanced_control[`ACR_BIT_GATE_NVM] |
    nvm_gate_open;
  assign reg_write_clk_en_out = ~advanced_control[`ACR_BIT_GATE_REG_WR] |
    write_in_progress_in;
  assign bus_clk_gating_en_out = advanced_control[`ACR_BIT_GATE_BUS];
  assign crc_enable_out = advanced_control[`ACR_BIT_CRC_ENABLE];
  // analog trims only leave the block, nothing here uses them
  assign bus_voltage_sel_out = advanced_control[`ACR_BIT_BUS_VOLTAGE];
  assign bandgap_chop_en_out = advanced_control[`ACR_BIT_BG_CHOP];

  acr_stall_monitor #(
    .STALL_CYCLES(STALL_CYCLES)
  ) u_stall (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .enable_in(advanced_control[`ACR_BIT_STALL_MON]),
    .state_in(calc_state_in),
    .stall_reset_out(calc_reset_out)
  );

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence seq_ctrl_write;
    cmd_valid_in && cmd_write_in && !busy &&
      cmd_code_in == `ACR_CMD_ADV_CTRL;
  endsequence

  sequence seq_wake_with_reinit;
    low_power_state_out && lpm_wake_in &&
      advanced_control[`ACR_BIT_REINIT_LPM_EXIT] ##1 1'b1;
  endsequence

  AST_WRITE_STORES: assert property (
    seq_ctrl_write |=> advanced_control == $past(cmd_wdata_in) &&
      cmd_done_out)
    else $error("control word write not stored");

  // back-to-back commands may legally hold done high a second cycle
  AST_READ_RETURNS: assert property (
    is_read_ctrl |=> cmd_rdata_out == $past(advanced_control) &&
      cmd_done_out ##1 (!cmd_done_out || $past(cmd_valid_in)))
    else $error("control word read wrong");

  AST_BUSY_REFUSES: assert property (
    cmd_valid_in && busy |=> cmd_refused_out && !cmd_done_out &&
      $stable(advanced_control))
    else $error("busy command not refused");

  AST_ADDR_NACK: assert property (
    busy && advanced_control[`ACR_BIT_BUS_RESP_INIT] |-> !addr_ack_out)
    else $error("address acked while busy and bit set");

  AST_REINIT_PULSE: assert property (
    seq_wake_with_reinit |-> reinit_request_out ##1 !reinit_request_out)
    else $error("reinit not pulsed on exit");

  AST_NO_REINIT: assert property (
    !advanced_control[`ACR_BIT_REINIT_LPM_EXIT] |-> !reinit_request_out)
    else $error("reinit while disabled");

  AST_LPM_BLOCKED: assert property (
    !advanced_control[`ACR_BIT_LPM_ENABLE] && !low_power_state_out
    |=> !low_power_state_out)
    else $error("entered low power while disabled");

  AST_CLEAR_FAULT: assert property (
    is_clear |=> clear_recorded_fault_out ==
      $past(advanced_control[`ACR_BIT_CLR_REC_FAULT]))
    else $error("fault erase gating wrong");

  AST_RESTORE_ON: assert property (
    turn_on_in && advanced_control[`ACR_BIT_RESTORE_ON]
    |=> restore_request_out && nvm_clk_en_out)
    else $error("restore not requested on turn-on");

  AST_CRC_FOLLOWS: assert property (
    seq_ctrl_write |=> crc_enable_out == $past(cmd_wdata_in[8]))
    else $error("crc enable does not follow write");

  AST_NVM_GATE: assert property (
    is_nvm_cmd |=> nvm_clk_en_out [*2])
    else $error("nvm clock not opened by command");

  AST_NVM_CLOSED: assert property (
    advanced_control[`ACR_BIT_GATE_NVM] && !nvm_gate_open
    |-> !nvm_clk_en_out)
    else $error("nvm clock runs while gated");

  AST_WR_CLK: assert property (
    advanced_control[`ACR_BIT_GATE_REG_WR] && !write_in_progress_in
    |-> !reg_write_clk_en_out)
    else $error("write clock runs outside a write");

  AST_BUS_GATE: assert property (
    seq_ctrl_write |=> bus_clk_gating_en_out == $past(cmd_wdata_in[0]))
    else $error("bus gating does not follow write");

endmodule : acr_advanced_control

// ---- hw/acr_stall_monitor.sv ----
`include "acr_consts.svh"

module acr_stall_monitor #(
  parameter int unsigned STALL_CYCLES = `ACR_STALL_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // control and observed state
  input wire logic enable_in,
  input wire logic [7:0] state_in,
  // reset pulse to the calculation machine
  output logic stall_reset_out
);

  localparam logic [`ACR_STALL_CNT_W-1:0] LIMIT =
    STALL_CYCLES[`ACR_STALL_CNT_W-1:0];

  logic [`ACR_STALL_CNT_W-1:0] count;
  logic [`ACR_STALL_CNT_W-1:0] next_count;
  logic [7:0] prev_state;
  logic fire;
  logic next_fire;

  // count cycles the state has not moved; fire once past the limit
  always_comb begin
    next_count = count;
    next_fire = 1'b0;
    if (!enable_in || state_in != prev_state || fire) begin
      next_count = '0;
    end else if (count == LIMIT) begin
      next_fire = 1'b1;
      next_count = '0;
    end else begin
      next_count = count + 1'b1;
    end
  end

  // registers; counter restarts after firing so the machine gets a new window
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      count <= '0;
      prev_state <= 8'h00;
      fire <= 1'b0;
    end else begin
      count <= next_count;
      prev_state <= state_in;
      fire <= next_fire;
    end
  end

  assign stall_reset_out = fire;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  AST_STALL_FIRES: assert property (
    enable_in && count == LIMIT && state_in == prev_state && !fire
    |=> stall_reset_out)
    else $error("stall monitor did not reset the machine");

  AST_STALL_QUIET: assert property (
    !enable_in |=> !stall_reset_out ##1 !stall_reset_out)
    else $error("stall reset while monitor disabled");

endmodule : acr_stall_monitor

// ---- shared/acr_consts.svh ----
`ifndef ACR_CONSTS_SVH
`define ACR_CONSTS_SVH

// bus command codes
`define ACR_CMD_ADV_CTRL 8'hF1
`define ACR_CMD_CLEAR_FAULTS 8'h08
`define ACR_CMD_NVM_STORE 8'h15
`define ACR_CMD_NVM_RESTORE 8'h16

// control word reset value
`define ACR_CTRL_RESET 16'h0000

// control word field positions
`define ACR_BIT_BUS_VOLTAGE 15
`define ACR_BIT_BUS_RESP_INIT 14
`define ACR_BIT_REINIT_LPM_EXIT 13
`define ACR_BIT_LPM_ENABLE 12
`define ACR_BIT_CLR_REC_FAULT 11
`define ACR_BIT_RESTORE_ON 9
`define ACR_BIT_CRC_ENABLE 8
`define ACR_BIT_STALL_MON 6
`define ACR_BIT_BG_CHOP 5
`define ACR_BIT_GATE_NVM 3
`define ACR_BIT_GATE_REG_WR 2
`define ACR_BIT_GATE_BUS 0

// stall monitor timing
`define ACR_CLK_MHZ 250
`define ACR_STALL_TIME_US 700
`define ACR_STALL_CYCLES (`ACR_STALL_TIME_US * `ACR_CLK_MHZ)
`define ACR_STALL_CNT_W 18

`endif

// ---- shared/acr_pkg.sv ----
package acr_pkg;

  // low-power sequencing states
  typedef enum logic [1:0] {
    ACR_ACTIVE,
    ACR_LOW_POWER,
    ACR_WAKE
  } acr_lpm_state_t;

  typedef logic [15:0] acr_word_t;

endpackage : acr_pkg

// ---- testbench/acr_host.sv ----
module acr_host (
  // clock
  input wire logic clk_in,
  // request from the bench
  input wire logic req_in,
  input wire logic req_write_in,
  input wire logic [7:0] req_code_in,
  input wire logic [15:0] req_wdata_in,
  // command port toward the device
  output logic cmd_valid_out = 1'b0,
  output logic cmd_write_out = 1'b0,
  output logic [7:0] cmd_code_out = 8'h00,
  output logic [15:0] cmd_wdata_out = 16'h0000,
  output logic write_in_progress_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;

  // one command per request, idle lines toggle so stale data never helps
  always @(posedge clk_in) begin
    cmd_valid_out <= req_in;
    cmd_write_out <= req_in ? req_write_in : ~cmd_write_out;
    cmd_code_out <= req_in ? req_code_in : ~cmd_code_out;
    write_in_progress_out <= req_in & req_write_in;
    cmd_wdata_out <= req_in ? (req_wdata_in & ~16'h0492) : ~cmd_wdata_out;
  end
endmodule : acr_host

// ---- testbench/tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic [7:0] req_code = 8'h00;
  logic [15:0] req_wdata = 16'h0000;
  logic [7:0] calc_state_in = 8'h00;
  logic cmd_valid_in, cmd_write_in, write_in_progress_in;
  logic [7:0] cmd_code_in;
  logic [15:0] cmd_wdata_in, cmd_rdata_out;
  logic addr_match_in = 1'b0, init_busy_in = 1'b0, nvm_busy_in = 1'b0;
  logic lpm_request_in = 1'b0, lpm_wake_in = 1'b0, turn_on_in = 1'b0;
  logic cmd_done_out, cmd_refused_out, addr_ack_out, low_power_state_out;
  logic reinit_request_out, restore_request_out, clear_recorded_fault_out;
  logic crc_enable_out, calc_reset_out, nvm_clk_en_out;
  logic reg_write_clk_en_out, bus_clk_gating_en_out;
  logic bus_voltage_sel_out, bandgap_chop_en_out;
  int errors = 0;
  int n_tests = 0;
  int i;

  always #2 clk_in = ~clk_in;

  acr_host HOST (.clk_in, .req_in(req), .req_write_in(req_write),
    .req_code_in(req_code), .req_wdata_in(req_wdata),
    .cmd_valid_out(cmd_valid_in), .cmd_write_out(cmd_write_in),
    .cmd_code_out(cmd_code_in), .cmd_wdata_out(cmd_wdata_in),
    .write_in_progress_out(write_in_progress_in));

  acr_advanced_control #(.STALL_CYCLES(20)) DUT (.clk_in, .sys_rst_in,
    .cmd_valid_in, .cmd_write_in, .cmd_code_in, .cmd_wdata_in,
    .cmd_rdata_out, .cmd_done_out, .cmd_refused_out, .addr_match_in,
    .addr_ack_out, .write_in_progress_in, .init_busy_in, .nvm_busy_in,
    .lpm_request_in, .lpm_wake_in, .low_power_state_out,
    .reinit_request_out, .turn_on_in, .restore_request_out,
    .clear_recorded_fault_out, .crc_enable_out, .calc_state_in,
    .calc_reset_out, .nvm_clk_en_out, .reg_write_clk_en_out,
    .bus_clk_gating_en_out, .bus_voltage_sel_out,
    .bandgap_chop_en_out);

  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one bus command, answer sampled the cycle after the device takes it
  task cmd(input logic w, input logic [7:0] c, input logic [15:0] d,
           input logic dn, input logic rf);
    @(posedge clk_in);
    req <= 1'b1;
    req_write <= w;
    req_code <= c;
    req_wdata <= d;
    @(posedge clk_in);
    req <= 1'b0;
    @(posedge clk_in);
    #1;
    check(cmd_done_out, dn);
    check(cmd_refused_out, rf);
  endtask : cmd

  task wr(input logic [15:0] d);
    cmd(1'b1, 8'hF1, d, 1'b1, 1'b0);
  endtask : wr

  // waits for the stall pulse, bounded at 40 cycles
  task stall_wait();
    @(posedge clk_in);
    calc_state_in <= calc_state_in + 8'h01;
    i = 0;
    do begin
      @(posedge clk_in);
      #1;
      i++;
    end while (calc_reset_out !== 1'b1 && i < 40);
  endtask : stall_wait

  task end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  // watchdog, the tests need well under 10 us
  initial begin
    #100us;
    errors++;
    end_sim();
  end

  initial begin
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    cmd(1'b0, 8'hF1, 16'h0000, 1'b1, 1'b0);
    check(cmd_rdata_out, 16'h0000);
    wr(16'hFFFF);
    cmd(1'b0, 8'hF1, 16'h0000, 1'b1, 1'b0);
    check(cmd_rdata_out, 16'hFB6D);
    check(crc_enable_out, 1'b1);
    check(bus_clk_gating_en_out, 1'b1);
    check(reg_write_clk_en_out, 1'b0);
    check(nvm_clk_en_out, 1'b0);
    check(bus_voltage_sel_out, 1'b1);
    check(bandgap_chop_en_out, 1'b1);
    $display("test word done");
    // busy with bit 14 set, then clear: address refused only while set, commands refused
    cmd(1'b1, 8'h15, 16'h0000, 1'b1, 1'b0);
    check(nvm_clk_en_out, 1'b1);
    @(posedge clk_in);
    addr_match_in <= 1'b1;
    #1;
    check(addr_ack_out, 1'b1);
    @(posedge clk_in);
    nvm_busy_in <= 1'b1;
    #1;
    check(addr_ack_out, 1'b0);
    cmd(1'b0, 8'hF1, 16'h0000, 1'b0, 1'b1);
    @(posedge clk_in);
    nvm_busy_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    check(nvm_clk_en_out, 1'b0);
    cmd(1'b1, 8'h16, 16'h0000, 1'b1, 1'b0);
    check(nvm_clk_en_out, 1'b1);
    wr(16'h0000);
    check(crc_enable_out, 1'b0);
    check(bus_voltage_sel_out, 1'b0);
    check(bandgap_chop_en_out, 1'b0);
    check(reg_write_clk_en_out, 1'b1);
    @(posedge clk_in);
    init_busy_in <= 1'b1;
    @(posedge clk_in);
    #1;
    check(addr_ack_out, 1'b1);
    cmd(1'b1, 8'hF1, 16'h0000, 1'b0, 1'b1);
    @(posedge clk_in);
    init_busy_in <= 1'b0;
    addr_match_in <= 1'b0;
    $display("test busy done");
    // low power entry and exit, with and without re-init
    for (int k = 0; k < 2; k++) begin
      wr(k == 0 ? 16'h3000 : 16'h1000);
      @(posedge clk_in);
      lpm_request_in <= 1'b1;
      @(posedge clk_in);
      lpm_request_in <= 1'b0;
      #1;
      check(low_power_state_out, 1'b1);
      lpm_wake_in <= 1'b1;
      @(posedge clk_in);
      lpm_wake_in <= 1'b0;
      #1;
      check(low_power_state_out, 1'b0);
      check(reinit_request_out, k == 0);
      @(posedge clk_in);
      #1;
      check(reinit_request_out, 1'b0);
    end
    wr(16'h0000);
    @(posedge clk_in);
    lpm_request_in <= 1'b1;
    @(posedge clk_in);
    lpm_request_in <= 1'b0;
    #1;
    check(low_power_state_out, 1'b0);
    $display("test low power done");
    // fault erase and restore on turn-on, both polarities
    for (int k = 0; k < 2; k++) begin
      wr(k == 0 ? 16'h0A00 : 16'h0000);
      cmd(1'b1, 8'h08, 16'h0000, 1'b1, 1'b0);
      check(clear_recorded_fault_out, k == 0);
      @(posedge clk_in);
      turn_on_in <= 1'b1;
      @(posedge clk_in);
      turn_on_in <= 1'b0;
      #1;
      check(restore_request_out, k == 0);
    end
    $display("test fault and restore done");
    wr(16'h0040);
    stall_wait();
    check(calc_reset_out, 1'b1);
    check(i >= 19, 1'b1);
    wr(16'h0000);
    stall_wait();
    check(calc_reset_out, 1'b0);
    $display("test stall done");
    end_sim();
  end
endmodule : tb
